// ---- logic/uem_defines.svh ----
// constants for the upper uncorrectable-error mask register
//
// Behaviour
// - a masked error's header is never captured into the header log
// - a masked error leaves the first-error pointer unchanged
// - a masked error sends no report toward the root complex
// - every error sets its status bit, masked or not
// - mask bits 17..22 are read-write, sticky and reset to zero
// - internal-error mask reads zero and ignores writes while reporting disabled
// - bits 23, 24 and 25 are read-only zero
// - the mask register sits at configuration offset 0x108
`ifndef UEM_DEFINES_SVH
`define UEM_DEFINES_SVH

// ----------------------------------------
// address and layout
// ----------------------------------------
`define UEM_MASK_OFFSET 12'h108
`define UEM_FIELD_LSB 17
`define UEM_FIELD_MSB 22
`define UEM_FIELD_NUM 6
`define UEM_WRITE_LANE 2
`define UEM_RECEIVER_OVERFLOW_BIT 17
`define UEM_MALFORMED_BIT 18
`define UEM_END_TO_END_CRC_BIT 19
`define UEM_UNSUPPORTED_REQUEST_BIT 20
`define UEM_ACCESS_CONTROL_BIT 21
`define UEM_INTERNAL_BIT 22
`define UEM_INTERNAL_IDX 5
`define UEM_UNSUPPORTED_MSB 25
`define UEM_UNSUPPORTED_LSB 23

// ----------------------------------------
// reset values and header width
// ----------------------------------------
`define UEM_MASK_RESET 6'h00
`define UEM_WORD_ZERO 32'h0000_0000
`define UEM_HEADER_WIDTH 128

`endif

// ---- logic/uem_pkg.sv ----
// types shared by the upper uncorrectable-error mask block
package uem_pkg;

    // configuration access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } uem_cfg_req_t;

    // configuration read answer
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } uem_cfg_rsp_t;

    // error events, one bit per mask field, with the offending header
    typedef struct packed {
        logic [5:0]   hit;
        logic [127:0] header;
    } uem_err_evt_t;

    // consequences of the events after masking
    typedef struct packed {
        logic [5:0]   status_set;
        logic [5:0]   log_hit;
        logic         fep_update;
        logic [4:0]   fep_value;
        logic         report;
        logic [127:0] header_log;
    } uem_err_out_t;

endpackage

// ---- logic/uem_mask_bit.sv ----
// one sticky read-write mask bit with write gating
module uem_mask_bit (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic wr_en,
    input  wire logic wr_val,
    input  wire logic hold_zero,
    output logic      mask_q
);
    // ----------------------------------------
    // sticky storage
    // ----------------------------------------
    // only the fundamental reset or hold_zero clears it; other resets do not reach here
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mask_q <= 1'b0;
        end else if (hold_zero) begin
            mask_q <= 1'b0;
        end else if (wr_en) begin
            mask_q <= wr_val;
        end
    end
endmodule

// ---- logic/uem_mask_upper.sv ----
// upper half of the uncorrectable-error mask register and its error gating
`include "uem_defines.svh"

module uem_mask_upper (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic hot_rst,
    input  wire logic internal_fault_report_enable,
    input  wire uem_pkg::uem_cfg_req_t cfg_req,
    output uem_pkg::uem_cfg_rsp_t cfg_rsp,
    input  wire uem_pkg::uem_err_evt_t err_evt,
    output uem_pkg::uem_err_out_t err_out
);
    import uem_pkg::*;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic addr_hit;
    logic wr_hit;
    logic [5:0] mask_q;
    logic [5:0] hold_zero;
    logic [5:0] live_hit;
    logic [4:0] first_idx;
    logic [31:0] read_word;

    assign addr_hit = (cfg_req.addr == `UEM_MASK_OFFSET);
    assign wr_hit = cfg_req.wr && addr_hit && cfg_req.be[`UEM_WRITE_LANE];

    // ----------------------------------------
    // mask storage
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `UEM_FIELD_NUM; gi++) begin : g_bit
            if (gi == `UEM_INTERNAL_IDX) begin : g_int
                assign hold_zero[gi] = !internal_fault_report_enable;
            end else begin : g_std
                assign hold_zero[gi] = 1'b0;
            end
            uem_mask_bit u_bit (
                .clock(clock),
                .sys_rst(sys_rst),
                .wr_en(wr_hit),
                .wr_val(cfg_req.wdata[`UEM_FIELD_LSB + gi]),
                .hold_zero(hold_zero[gi]),
                .mask_q(mask_q[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_comb begin
        read_word = `UEM_WORD_ZERO;
        read_word[`UEM_FIELD_MSB:`UEM_FIELD_LSB] = mask_q;
        if (!internal_fault_report_enable) begin
            read_word[`UEM_INTERNAL_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || hot_rst) begin
            cfg_rsp.valid <= 1'b0;
        end else begin
            cfg_rsp.valid <= cfg_req.rd && addr_hit;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || hot_rst) begin
            cfg_rsp.data <= `UEM_WORD_ZERO;
        end else if (cfg_req.rd && addr_hit) begin
            cfg_rsp.data <= read_word;
        end
    end

    // ----------------------------------------
    // error gating
    // ----------------------------------------
    assign live_hit = err_evt.hit & ~mask_q;

    always_comb begin
        first_idx = 5'h00;
        for (int i = `UEM_FIELD_NUM - 1; i >= 0; i--) begin
            if (live_hit[i]) begin
                first_idx = 5'(`UEM_FIELD_LSB + i);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || hot_rst) begin
            err_out.status_set <= 6'h00;
        end else begin
            err_out.status_set <= err_evt.hit;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || hot_rst) begin
            err_out.log_hit <= 6'h00;
            err_out.report <= 1'b0;
        end else begin
            err_out.log_hit <= live_hit;
            err_out.report <= |live_hit;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || hot_rst) begin
            err_out.fep_update <= 1'b0;
            err_out.fep_value <= 5'h00;
        end else begin
            err_out.fep_update <= |live_hit;
            if (|live_hit) begin
                err_out.fep_value <= first_idx;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            err_out.header_log <= {`UEM_HEADER_WIDTH{1'b0}};
        end else if (|live_hit) begin
            err_out.header_log <= err_evt.header;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst || hot_rst);

    sequence s_cfg_write;
        wr_hit && internal_fault_report_enable;
    endsequence

    sequence s_masked_only;
        (err_evt.hit != 6'h00) && ((err_evt.hit & ~mask_q) == 6'h00);
    endsequence

    status_all_a: assert property (
        1'b1 |=> err_out.status_set == $past(err_evt.hit))
        else $error("status set does not follow every event");

    log_masked_a: assert property (
        1'b1 |=> (err_out.log_hit & $past(mask_q)) == 6'h00)
        else $error("masked event reached the log");

    header_hold_a: assert property (
        s_masked_only |=> $stable(err_out.header_log))
        else $error("header captured for a masked event");

    header_take_a: assert property (
        (live_hit != 6'h00) |=> err_out.header_log == $past(err_evt.header))
        else $error("header of unmasked event not captured");

    fep_hold_a: assert property (
        s_masked_only |=> !err_out.fep_update ##0 $stable(err_out.fep_value))
        else $error("first error pointer moved on a masked event");

    report_gate_a: assert property (
        1'b1 |=> err_out.report == |($past(err_evt.hit) & ~$past(mask_q)))
        else $error("report does not follow unmasked events");

    internal_zero_a: assert property (
        !internal_fault_report_enable |=> !mask_q[`UEM_INTERNAL_IDX])
        else $error("internal mask set while reporting disabled");

    mask_write_a: assert property (
        s_cfg_write |=> mask_q == $past(cfg_req.wdata[`UEM_FIELD_MSB:`UEM_FIELD_LSB]))
        else $error("mask write not stored");

    read_zero_a: assert property (
        cfg_rsp.valid |-> cfg_rsp.data[`UEM_UNSUPPORTED_MSB:`UEM_UNSUPPORTED_LSB] == 3'h0)
        else $error("unsupported mask bits read nonzero");

    reserved_zero_a: assert property (
        cfg_rsp.valid |-> cfg_rsp.data[31:26] == 6'h00)
        else $error("reserved bits read nonzero");

    read_decode_a: assert property (
        cfg_req.rd && !addr_hit |=> !cfg_rsp.valid)
        else $error("read answered off the mask offset");

    sticky_hold_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        hot_rst && !wr_hit && internal_fault_report_enable |=> $stable(mask_q))
        else $error("sticky mask lost on hot reset");

    reset_clear_a: assert property (
        @(posedge clock) disable iff (1'b0)
        sys_rst |=> mask_q == `UEM_MASK_RESET)
        else $error("mask not cleared by fundamental reset");

endmodule

// ---- verif/uem_root_model.sv ----
// root-complex stand-in that counts incoming error reports
module uem_root_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic report,
    output logic [31:0] report_count
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            report_count <= 32'h0000_0000;
        end else if (report) begin
            report_count <= report_count + 32'h0000_0001;
        end
    end
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the upper uncorrectable-error mask block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import uem_pkg::*;
    logic clock, sys_rst, hot_rst, ie_en;
    uem_cfg_req_t req;
    uem_cfg_rsp_t rsp;
    uem_err_evt_t evt;
    uem_err_out_t eo;
    logic [31:0] rpt_n;
    int err_count, n_tests, cyc;
    uem_mask_upper uut (.clock(clock), .sys_rst(sys_rst), .hot_rst(hot_rst),
        .internal_fault_report_enable(ie_en), .cfg_req(req), .cfg_rsp(rsp),
        .err_evt(evt), .err_out(eo));
    uem_root_model rc (.clock(clock), .sys_rst(sys_rst), .report(eo.report),
        .report_count(rpt_n));
    // ----------------------------------------
    // clock, timeout and tasks
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clock);
        #1 req = '{1'b1, 1'b0, a, d, be};
        @(posedge clock);
        #1 req.wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic vexp);
        @(posedge clock);
        #1 req = '{1'b0, 1'b1, a, 32'h0000_0000, 4'h0};
        @(posedge clock);
        #1 req.rd = 1'b0;
        chk(rsp.valid, vexp, "read valid");
        if (vexp) chk(rsp.data, exp, "read data");
    endtask
    task automatic ev(input logic [5:0] h, input logic [127:0] hd, input logic [5:0] lg,
                      input logic [4:0] fp, input logic [127:0] hx);
        @(posedge clock);
        #1 evt = '{h, hd};
        @(posedge clock);
        #1 evt.hit = 6'h00;
        chk(eo.status_set, h, "status set");
        chk(eo.log_hit, lg, "log hit");
        chk(eo.fep_update, |lg, "pointer update");
        chk(eo.report, |lg, "report");
        chk(eo.fep_value, fp, "pointer value");
        chk(eo.header_log, hx, "header log");
    endtask
    task automatic pulse_rst(input logic fund);
        @(posedge clock);
        #1 {sys_rst, hot_rst} = {fund, ~fund};
        @(posedge clock);
        #1 {sys_rst, hot_rst} = 2'b00;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {sys_rst, hot_rst, ie_en} = 3'b101;
        req = '0;
        evt = '0;
        repeat (2) @(posedge clock);
        #1 sys_rst = 1'b0;
        rd(12'h108, 32'h0000_0000, 1'b1);
        wr(12'h108, 32'hFFFF_FFFF, 4'hF);
        rd(12'h108, 32'h007E_0000, 1'b1);
        rd(12'h10C, 32'h0000_0000, 1'b0);
        wr(12'h10C, 32'h0000_0000, 4'hF);
        wr(12'h108, 32'h0000_0000, 4'hB);
        rd(12'h108, 32'h007E_0000, 1'b1);
        $display("test register access done");
        wr(12'h108, 32'h0002_0000, 4'h4);
        ev(6'h03, 128'hA1, 6'h02, 5'd18, 128'hA1);
        ev(6'h01, 128'hB2, 6'h00, 5'd18, 128'hA1);
        $display("test masked events done");
        pulse_rst(1'b0);
        chk(eo.fep_value, 5'h00, "pointer not cleared by hot reset");
        chk(eo.header_log, 128'hA1, "header lost on hot reset");
        rd(12'h108, 32'h0002_0000, 1'b1);
        $display("test sticky mask done");
        wr(12'h108, 32'h0040_0000, 4'h4);
        rd(12'h108, 32'h0040_0000, 1'b1);
        ie_en = 1'b0;
        rd(12'h108, 32'h0000_0000, 1'b1);
        wr(12'h108, 32'h0040_0000, 4'h4);
        rd(12'h108, 32'h0000_0000, 1'b1);
        ev(6'h20, 128'hC3, 6'h20, 5'd22, 128'hC3);
        ie_en = 1'b1;
        ev(6'h1C, 128'hD4, 6'h1C, 5'h13, 128'hD4);
        rd(12'h108, 32'h0000_0000, 1'b1);
        $display("test internal enable done");
        chk(rpt_n, 32'h0000_0003, "report count");
        wr(12'h108, 32'h007E_0000, 4'h4);
        pulse_rst(1'b1);
        chk(eo.header_log, 128'h0, "header kept through fundamental reset");
        rd(12'h108, 32'h0000_0000, 1'b1);
        $display("test fundamental reset done");
        end_sim();
    end
endmodule
